// [verilog/cstl_pkg.sv]
// constants and types for the self-test sequencer and lockout controller
// assumes one 100 MHz clock and a synchronous, active-high reset
`default_nettype none
package cstl_pkg;

   // ************************************************************
   // sequencer states and status codes
   // ************************************************************
   typedef enum logic [1:0] {
      CSTL_S_START = 2'b00,
      CSTL_S_WAIT  = 2'b01,
      CSTL_S_OPER  = 2'b10,
      CSTL_S_LOCK  = 2'b11
   } cstl_state_t;

   localparam logic [1:0] CSTL_STAT_TEST = 2'h1;
   localparam logic [1:0] CSTL_STAT_OPER = 2'h2;
   localparam logic [1:0] CSTL_STAT_LOCK = 2'h3;

   // ************************************************************
   // known_answer_test set, run in this order
   // ************************************************************
   typedef enum logic [3:0] {
      CSTL_KAT_AES_CCM_ENC = 4'h0,
      CSTL_KAT_AES_CCM_DEC = 4'h1,
      CSTL_KAT_AES_ECB_ENC = 4'h2,
      CSTL_KAT_AES_ECB_DEC = 4'h3,
      CSTL_KAT_TDES_ENC    = 4'h4,
      CSTL_KAT_TDES_DEC    = 4'h5,
      CSTL_KAT_HMAC_SHA1   = 4'h6,
      CSTL_KAT_HMAC_SHA256 = 4'h7,
      CSTL_KAT_AES_CMAC    = 4'h8
   } cstl_kat_t;

   localparam logic [3:0] CSTL_KAT_FIRST = 4'h0;
   localparam logic [3:0] CSTL_KAT_LAST  = 4'h8;

   // ************************************************************
   // key storage defaults
   // ************************************************************
   localparam int CSTL_KEY_W     = 256;
   localparam int CSTL_KEY_SLOTS = 8;
   localparam int CSTL_KEY_RESET = 0;

endpackage
`default_nettype wire

// [verilog/cstl_selftest.sv]
// self-test sequencer, lockout and secret_parameter storage of the crypto_module
// assumes the algorithm datapath runs one known_answer_test per start pulse,
// on the same clock, and answers with a one-cycle done pulse and a pass level
//
// Functional notes
// (RULE1) Self-test starts on its own after power-up reset, no command needed.
// (RULE2) The whole test set is one atomic action ending in pass or fail only.
// (RULE3) A passing outcome moves the block into the operational state.
// (RULE4) A failing outcome enters an error state with no crypto service.
// (RULE5) A module reset event reruns the complete self-test sequence.
// (RULE6) Testing begins immediately on reset and runs until every test is done; the code stops at the first failing test.
// (RULE7) Services reach external requesters only after a passing self-test.
// (RULE8) Any test error locks the block and refuses every external access; a request with RST_I high and MOD_RESET_I low gets neither grant nor refuse.
// (RULE9) While locked only a reset is obeyed, and it reruns the full self-test.
// (RULE10) A failing retry keeps the block locked, with no limit on retries.
// (RULE11) The host leaves the error state or forces testing by power cycle or reset.
// (RULE12) The test set covers AES CCM/ECB both ways, TDES ECB both ways, HMAC SHA-1/256, AES-CMAC.
// (RULE13) Keys live in internal key storage or in a legacy key register.
// (RULE14) A key is erased on module reset and destroyed when its slot is rewritten.
// (RULE15) Every reset clears all secret_parameters to zero.
// (RULE16) Key storage is write-only; reads return zeros.
// (RULE17) A status output tells testing, operational and locked apart.
`timescale 1ns/1ps
`default_nettype none
module cstl_selftest #(
   parameter int KEY_W     = cstl_pkg::CSTL_KEY_W,
   parameter int KEY_SLOTS = cstl_pkg::CSTL_KEY_SLOTS
) (
   // clock and reset
   input  wire logic                         SYS_CLK_I,
   input  wire logic                         RST_I,
   // module reset event from host
   input  wire logic                         MOD_RESET_I,
   // known_answer_test datapath
   output logic                              KAT_START_O,
   output logic [3:0]                        KAT_SEL_O,
   input  wire logic                         KAT_DONE_I,
   input  wire logic                         KAT_PASS_I,
   // external service access
   input  wire logic                         ACC_REQ_I,
   output logic                              ACC_GRANT_O,
   output logic                              ACC_REFUSE_O,
   output logic                              SVC_EN_O,
   output logic [1:0]                        STATUS_O,
   // key storage
   input  wire logic                         KEY_WR_I,
   input  wire logic                         KEY_LEGACY_I,
   input  wire logic [$clog2(KEY_SLOTS)-1:0] KEY_SLOT_I,
   input  wire logic [KEY_W-1:0]             KEY_DATA_I,
   input  wire logic                         KEY_RD_I,
   output logic [KEY_W-1:0]                  KEY_RD_DATA_O,
   input  wire logic                         ENG_LEGACY_I,
   input  wire logic [$clog2(KEY_SLOTS)-1:0] ENG_SLOT_I,
   output logic [KEY_W-1:0]                  KEY_ENG_O
);

   // ************************************************************
   // state
   // ************************************************************
   cstl_pkg::cstl_state_t state_reg;
   cstl_pkg::cstl_state_t state_next;
   logic [3:0]            kat_idx_reg;
   logic [3:0]            kat_idx_next;
   logic [KEY_W-1:0]      key_mem [KEY_SLOTS];
   logic [KEY_W-1:0]      legacy_key_reg;
   logic                  kat_start_reg;
   logic                  grant_reg;
   logic                  refuse_reg;
   logic                  svc_en_reg;
   logic [1:0]            status_reg;
   logic [KEY_W-1:0]      key_eng_reg;
   logic                  keys_zero;

   // ************************************************************
   // decode
   // ************************************************************
   // a module reset event acts like the reset pin, from any state, except that a request in that cycle is refused
   wire restart     = RST_I | MOD_RESET_I;
   wire in_oper     = (state_reg == cstl_pkg::CSTL_S_OPER);
   wire in_wait     = (state_reg == cstl_pkg::CSTL_S_WAIT);
   wire kat_fail    = in_wait & KAT_DONE_I & ~KAT_PASS_I;
   wire kat_ok      = in_wait & KAT_DONE_I & KAT_PASS_I;
   wire kat_is_last = (kat_idx_reg == cstl_pkg::CSTL_KAT_LAST);
   wire oper_next   = (state_next == cstl_pkg::CSTL_S_OPER);
   // keys are only accepted once the block is released
   wire key_wr_ok   = KEY_WR_I & in_oper & ~MOD_RESET_I;
   wire [KEY_W-1:0] eng_key = ENG_LEGACY_I ? legacy_key_reg : key_mem[ENG_SLOT_I];

   function automatic logic [1:0] status_of(input cstl_pkg::cstl_state_t s);
      unique case (s)
         cstl_pkg::CSTL_S_START: status_of = cstl_pkg::CSTL_STAT_TEST;
         cstl_pkg::CSTL_S_WAIT:  status_of = cstl_pkg::CSTL_STAT_TEST;
         cstl_pkg::CSTL_S_OPER:  status_of = cstl_pkg::CSTL_STAT_OPER;
         cstl_pkg::CSTL_S_LOCK:  status_of = cstl_pkg::CSTL_STAT_LOCK;
      endcase
   endfunction

   // ************************************************************
   // sequencer
   // ************************************************************
   always_comb begin
      state_next   = state_reg;
      kat_idx_next = kat_idx_reg;
      unique case (state_reg)
         // (RULE12) walk every test
         cstl_pkg::CSTL_S_START: begin
            state_next = cstl_pkg::CSTL_S_WAIT;
         end
         // (RULE2) single pass or fail
         cstl_pkg::CSTL_S_WAIT: begin
            if (kat_fail) begin
               // (RULE4) fail locks out
               state_next = cstl_pkg::CSTL_S_LOCK;
            end else if (kat_ok && kat_is_last) begin
               // (RULE3) pass releases
               state_next = cstl_pkg::CSTL_S_OPER;
            end else if (kat_ok) begin
               state_next   = cstl_pkg::CSTL_S_START;
               kat_idx_next = kat_idx_reg + 4'h1;
            end
         end
         cstl_pkg::CSTL_S_OPER: begin
            state_next = cstl_pkg::CSTL_S_OPER;
         end
         // (RULE10) locked until reset
         cstl_pkg::CSTL_S_LOCK: begin
            state_next = cstl_pkg::CSTL_S_LOCK;
         end
      endcase
   end

   // (RULE1) automatic start on reset
   // (RULE5) module reset reruns
   // (RULE9) only reset leaves lock
   always_ff @(posedge SYS_CLK_I) begin
      if (restart) begin
         state_reg   <= cstl_pkg::CSTL_S_START;
         kat_idx_reg <= cstl_pkg::CSTL_KAT_FIRST;
      end else begin
         state_reg   <= state_next;
         kat_idx_reg <= kat_idx_next;
      end
   end

   // (RULE6) start pulse per test
   always_ff @(posedge SYS_CLK_I) begin
      if (restart) begin
         kat_start_reg <= 1'b0;
      end else begin
         kat_start_reg <= (state_reg == cstl_pkg::CSTL_S_START);
      end
   end

   // ************************************************************
   // service gating and status
   // ************************************************************
   // (RULE7) release only after pass
   // (RULE8) refuse unless released, except in a cycle with RST_I high and MOD_RESET_I low
   // (RULE17) status follows state
   always_ff @(posedge SYS_CLK_I) begin
      if (restart) begin
         grant_reg  <= 1'b0;
         refuse_reg <= ACC_REQ_I & MOD_RESET_I;
         svc_en_reg <= 1'b0;
         status_reg <= cstl_pkg::CSTL_STAT_TEST;
      end else begin
         grant_reg  <= ACC_REQ_I & in_oper;
         refuse_reg <= ACC_REQ_I & ~in_oper;
         svc_en_reg <= oper_next;
         status_reg <= status_of(state_next);
      end
   end

   // ************************************************************
   // key storage
   // ************************************************************
   // (RULE14) erase on reset, overwrite
   // (RULE15) clear all on reset
   always_ff @(posedge SYS_CLK_I) begin
      if (restart) begin
         for (int i = 0; i < KEY_SLOTS; i++) begin
            key_mem[i] <= KEY_W'(cstl_pkg::CSTL_KEY_RESET);
         end
         legacy_key_reg <= KEY_W'(cstl_pkg::CSTL_KEY_RESET);
      end else if (key_wr_ok && KEY_LEGACY_I) begin
         legacy_key_reg <= KEY_DATA_I;
      end else if (key_wr_ok) begin
         key_mem[KEY_SLOT_I] <= KEY_DATA_I;
      end
   end

   // (RULE13) storage or legacy key
   // (RULE16) host reads give zeros
   // the engine sees keys only while released; no path leads a key outward
   always_ff @(posedge SYS_CLK_I) begin
      if (restart) begin
         key_eng_reg <= KEY_W'(cstl_pkg::CSTL_KEY_RESET);
      end else begin
         key_eng_reg <= oper_next ? eng_key : KEY_W'(cstl_pkg::CSTL_KEY_RESET);
      end
   end

   assign KAT_START_O   = kat_start_reg;
   assign KAT_SEL_O     = kat_idx_reg;
   assign ACC_GRANT_O   = grant_reg;
   assign ACC_REFUSE_O  = refuse_reg;
   assign SVC_EN_O      = svc_en_reg;
   assign STATUS_O      = status_reg;
   assign KEY_ENG_O     = key_eng_reg;
   assign KEY_RD_DATA_O = KEY_W'(cstl_pkg::CSTL_KEY_RESET);

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   always_comb begin
      keys_zero = (legacy_key_reg == '0);
      for (int i = 0; i < KEY_SLOTS; i++) begin
         keys_zero = keys_zero & (key_mem[i] == '0);
      end
   end

   boot_start_a: assert property ($fell(RST_I) |-> ##1 (KAT_START_O && KAT_SEL_O == 4'h0)) // RULE1
      else $error("self-test did not start after reset");
   modrst_rerun_a: assert property (MOD_RESET_I |=> ##1 (KAT_START_O && KAT_SEL_O == 4'h0)) // RULE5
      else $error("module reset did not rerun self-test");
   lock_reset_a: assert property (state_reg == cstl_pkg::CSTL_S_LOCK && MOD_RESET_I |=> STATUS_O == 2'h1) // RULE9
      else $error("reset did not leave lock");
   fail_lock_a: assert property (kat_fail && !MOD_RESET_I |=> STATUS_O == 2'h3 && !SVC_EN_O) // RULE4
      else $error("failed test did not lock");
   pass_oper_a: assert property (kat_ok && kat_is_last && !MOD_RESET_I |=> STATUS_O == 2'h2 && SVC_EN_O) // RULE3
      else $error("passing test set did not release");
   next_test_a: assert property (kat_ok && !kat_is_last && !MOD_RESET_I
                                 |=> ##1 (KAT_START_O && KAT_SEL_O == $past(kat_idx_reg, 2) + 4'h1)) // RULE12
      else $error("test sequence skipped or stalled");
   lock_stays_a: assert property (STATUS_O == 2'h3 && !MOD_RESET_I |=> STATUS_O == 2'h3) // RULE10
      else $error("lock left without reset");
   refuse_access_a: assert property (ACC_REQ_I && !in_oper |=> ACC_REFUSE_O && !ACC_GRANT_O) // RULE8
      else $error("access not refused before release");
   grant_access_a: assert property (ACC_GRANT_O |-> $past(in_oper) && SVC_EN_O) // RULE7
      else $error("access granted while not released");
   key_zeroize_a: assert property (MOD_RESET_I |=> keys_zero && KEY_ENG_O == '0) // RULE15
      else $error("keys not zeroized on reset");
   key_readout_a: assert property (KEY_RD_I |=> KEY_RD_DATA_O == '0) // RULE16
      else $error("key value visible on read");

   pass_cov: cover property (kat_ok && kat_is_last);
   fail_cov: cover property (kat_fail);
   retry_cov: cover property (STATUS_O == 2'h3 ##1 MOD_RESET_I ##[1:40] STATUS_O == 2'h2);

endmodule
`default_nettype wire

// [verification/cstl_kat_model.sv]
// datapath stand-in answering each known_answer_test start
// assumes the sequencer's clock; rst_i is any reset of the block
`timescale 1ns/1ps
`default_nettype none
module cstl_kat_model (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // test control
   input  wire logic       start_i,
   input  wire logic [3:0] sel_i,
   input  wire logic [3:0] fail_i,
   input  wire logic       slow_i,
   // answer and bookkeeping
   output logic            done_o,
   output logic            pass_o,
   output logic [3:0]      cnt_o,
   output logic            bad_o
);
   logic [2:0] wait_reg;
   logic       junk_reg = 1'b0;
   assign done_o = (wait_reg == 3'h1);
   // pass only means something with done, so it toggles otherwise
   assign pass_o = done_o ? (sel_i != fail_i) : junk_reg;
   always_ff @(posedge clk_i) begin
      junk_reg <= ~junk_reg;
      if (rst_i) begin
         wait_reg <= 3'h0;
         cnt_o    <= 4'h0;
         bad_o    <= 1'b0;
      end else if (start_i) begin
         wait_reg <= slow_i ? 3'h6 : 3'h1;
         cnt_o    <= cnt_o + 4'h1;
         bad_o    <= bad_o | (sel_i != cnt_o);
      end else if (wait_reg != 3'h0) begin
         wait_reg <= wait_reg - 3'h1;
      end
   end
endmodule
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the self-test sequencer and lockout
// assumes the datapath stand-in cstl_kat_model
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         mrst = 1'b0;
   logic         req = 1'b0;
   logic         wr = 1'b0;
   logic         leg = 1'b0;
   logic         rd = 1'b0;
   logic         eleg = 1'b0;
   logic [2:0]   slot = 3'h0;
   logic [2:0]   eslot = 3'h2;
   logic [255:0] kd = '0;
   logic [3:0]   fsel = 4'hf;
   logic         slow = 1'b0;
   logic         start, done, pass, grant, refuse, svc, bad;
   logic [3:0]   sel, cnt;
   logic [1:0]   stat;
   logic [255:0] rdat, ekey;
   int           fails = 0;
   int           n_compared = 0;
   int           cyc = 0;
   cstl_selftest DUT (.SYS_CLK_I(clk), .RST_I(rst), .MOD_RESET_I(mrst),
      .KAT_START_O(start), .KAT_SEL_O(sel), .KAT_DONE_I(done), .KAT_PASS_I(pass),
      .ACC_REQ_I(req), .ACC_GRANT_O(grant), .ACC_REFUSE_O(refuse), .SVC_EN_O(svc),
      .STATUS_O(stat), .KEY_WR_I(wr), .KEY_LEGACY_I(leg), .KEY_SLOT_I(slot),
      .KEY_DATA_I(kd), .KEY_RD_I(rd), .KEY_RD_DATA_O(rdat), .ENG_LEGACY_I(eleg),
      .ENG_SLOT_I(eslot), .KEY_ENG_O(ekey));
   cstl_kat_model kat (.clk_i(clk), .rst_i(rst | mrst), .start_i(start), .sel_i(sel),
      .fail_i(fsel), .slow_i(slow), .done_o(done), .pass_o(pass), .cnt_o(cnt), .bad_o(bad));
   always #5 clk = ~clk;
   // a hung sequence must not stall the run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (fails == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmp_v(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_k(input logic [255:0] got, input logic [255:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_stat(input logic [1:0] exp);
      int i;
      i = 0;
      while (stat === 2'h1 && i < 200) begin
         step(1);
         i++;
      end
      cmp_v({2'h0, stat}, {2'h0, exp});
   endtask
   task automatic access(input logic g);
      req = 1'b1;
      step(1);
      req = 1'b0;
      cmp_v({2'h0, grant, refuse}, {2'h0, g, ~g});
      step(1);
      cmp_v({2'h0, grant, refuse}, 4'h0);
   endtask
   task automatic wr_key(input logic [2:0] s, input logic [255:0] d);
      wr = 1'b1;
      slot = s;
      kd = d;
      step(1);
      wr = 1'b0;
   endtask
   task automatic mod_reset();
      mrst = 1'b1;
      step(1);
      mrst = 1'b0;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_powerup();
      cmp_v({2'h0, stat}, 4'h1);
      access(1'b0);
      wait_stat(2'h2);
      cmp_v(cnt, 4'h9);
      cmp_v({3'h0, bad}, 4'h0);
      cmp_v({3'h0, svc}, 4'h1);
      access(1'b1);
      access(1'b1);
   endtask
   task automatic t_keys();
      wr_key(3'h2, {8{32'h1234abcd}});
      step(1);
      cmp_k(ekey, {8{32'h1234abcd}});
      rd = 1'b1;
      step(1);
      cmp_k(rdat, '0);
      rd = 1'b0;
      wr_key(3'h2, {8{32'h5a5a0f0f}});
      step(1);
      cmp_k(ekey, {8{32'h5a5a0f0f}});
      leg = 1'b1;
      wr_key(3'h5, {8{32'hc3c3_7e7e}});
      leg = 1'b0;
      eleg = 1'b1;
      step(1);
      cmp_k(ekey, {8{32'hc3c37e7e}});
   endtask
   task automatic t_modreset();
      mod_reset();
      cmp_v({2'h0, stat}, 4'h1);
      cmp_v({3'h0, svc}, 4'h0);
      wait_stat(2'h2);
      cmp_v(cnt, 4'h9);
      cmp_k(ekey, '0);
      eleg = 1'b0;
      step(1);
      cmp_k(ekey, '0);
   endtask
   task automatic t_fail();
      fsel = 4'h4;
      slow = 1'b1;
      mod_reset();
      wait_stat(2'h3);
      cmp_v(cnt, 4'h5);
      cmp_v({3'h0, svc}, 4'h0);
      access(1'b0);
      step(20);
      cmp_v({2'h0, stat}, 4'h3);
      cmp_v(cnt, 4'h5);
      fsel = 4'h8;
      mod_reset();
      wait_stat(2'h3);
      cmp_v(cnt, 4'h9);
      access(1'b0);
      fsel = 4'hf;
      slow = 1'b0;
      mod_reset();
      wait_stat(2'h2);
      access(1'b1);
   endtask
   task automatic t_powercycle();
      wr_key(3'h2, {8{32'h0f1e2d3c}});
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      step(1);
      cmp_v({2'h0, stat}, 4'h1);
      cmp_v({3'h0, svc}, 4'h0);
      wait_stat(2'h2);
      cmp_v(cnt, 4'h9);
      cmp_v({3'h0, bad}, 4'h0);
      cmp_k(ekey, '0);
   endtask
   initial begin
      step(8);
      rst = 1'b0;
      step(1);
      t_powerup();
      t_keys();
      t_modreset();
      t_fail();
      t_powercycle();
      print_verdict();
   end
endmodule
`default_nettype wire
